// ### rtl/rtcs_pkg.sv
package rtcs_pkg;
  // ==========================================
  // Register map (word indices; byte address is the index shifted left by two)
  localparam logic [3:0] ADDR_STATUS = 4'h0;
  localparam logic [3:0] ADDR_IRQ_EN = 4'h1;
  localparam logic [3:0] ADDR_PROTECT = 4'h2;
  localparam logic [3:0] ADDR_COMP_CFG = 4'h3;
  localparam logic [3:0] ADDR_FREE_CNT = 4'h4;
  localparam logic [3:0] ADDR_MODULO = 4'h5;
  localparam logic [3:0] ADDR_SECONDS = 4'h6;
  localparam logic [3:0] ADDR_CTRL = 4'h7;
  localparam int ADDR_W = 4;
  // ==========================================
  // Field positions
  localparam int BIT_LOAD = 7;
  localparam int BIT_HOUR = 5;
  localparam int BIT_MIN = 4;
  localparam int BIT_SEC = 3;
  localparam int BIT_COMP = 2;
  localparam int BIT_TICK = 0;
  localparam logic [7:0] EVENT_MASK = 8'h3d;
  localparam int CCS_HI = 7;
  localparam int CCS_LO = 6;
  localparam int Q_HI = 5;
  localparam int PKEY_HI = 7;
  localparam int PKEY_LO = 6;
  localparam int CTRL_EN = 0;
  // ==========================================
  // Protection key sequence
  localparam logic [1:0] KEY_LOCK = 2'h2;
  localparam logic [1:0] KEY_U0 = 2'h0;
  localparam logic [1:0] KEY_U1 = 2'h1;
  localparam logic [1:0] KEY_U2 = 2'h3;
  localparam logic [1:0] KEY_U3 = 2'h2;
  // ==========================================
  // Counts and reset values
  localparam logic [15:0] CNT_RST = 16'h0000;
  localparam logic [15:0] MOD_RST = 16'h0000;
  localparam logic [5:0] SEC_MAX = 6'h3b;
  localparam logic [5:0] MIN_MAX = 6'h3b;
  localparam logic [4:0] HOUR_MAX = 5'h17;
  localparam logic [6:0] CYC_5 = 7'h05;
  localparam logic [6:0] CYC_15 = 7'h0f;
  localparam logic [6:0] CYC_30 = 7'h1e;
  localparam logic [6:0] CYC_60 = 7'h3c;
  localparam logic [1:0] TICKS_PER_SEC = 2'h3;
  localparam int LOAD_CYCLES = 2;
endpackage

// ### rtl/rtcs_prot.sv
`timescale 1ns/1ns
`default_nettype none
module rtcs_prot
  import rtcs_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Key writes
  input wire logic key_wr,
  input wire logic [1:0] key_val,
  // State
  output logic locked_ff
);
  // ==========================================
  // Sequence tracker
  typedef enum logic [4:0] {
    ST_IDLE = 5'h01,
    ST_L1 = 5'h02,
    ST_U1 = 5'h04,
    ST_U2 = 5'h08,
    ST_U3 = 5'h10
  } rtcs_pst_t;
  rtcs_pst_t st_ff;
  rtcs_pst_t nxt_st;

  always_comb begin
    nxt_st = st_ff;
    if (key_wr) begin
      case (st_ff)
        ST_IDLE: nxt_st = (!locked_ff && key_val == KEY_LOCK) ? ST_L1 :
                          (locked_ff && key_val == KEY_U0) ? ST_U1 : ST_IDLE;
        ST_L1: nxt_st = ST_IDLE;
        ST_U1: nxt_st = (key_val == KEY_U1) ? ST_U2 : ST_IDLE;
        ST_U2: nxt_st = (key_val == KEY_U2) ? ST_U3 : ST_IDLE;
        ST_U3: nxt_st = ST_IDLE;
        default: nxt_st = ST_IDLE;
      endcase
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      st_ff <= ST_IDLE;
    end else begin
      st_ff <= nxt_st;
    end
  end

  // Two %10 writes lock; %00 %01 %11 %10 unlocks
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      locked_ff <= 1'b0;
    end else if (key_wr && st_ff == ST_L1 && key_val == KEY_LOCK) begin
      locked_ff <= 1'b1;
    end else if (key_wr && st_ff == ST_U3 && key_val == KEY_U3) begin
      locked_ff <= 1'b0;
    end
  end
endmodule
`default_nettype wire

// ### rtl/rtcs_top.sv
// Operation
// - Interrupt request when any event flag and its enable are both set.
// - Load bit 7 sets during config copy, clears after; writes ignored.
// - Modulo and compensation config writes ignored while load bit set.
// - Hour flag bit 5 sets on every hour increment.
// - Minute flag bit 4 sets on every minute increment.
// - Second flag bit 3 sets on every second increment.
// - Compensation flag bit 2 sets at last second of each cycle.
// - Tick flag bit 0 sets on every 4 Hz tick.
// - Writing 1 clears an event flag, 0 no effect; reset clears all.
// - Cycle select bits 7:6 give 5, 15, 30 or 60 seconds.
// - Counter first matches modulo+1 Q times, then modulo for the rest.
// - With Q zero, modulo+1 matching never happens.
// - Free-running 16-bit count readable, writes ignored, reset zero.
// - Modulo register holds rollover value, resets to zero.
// - Reading seconds returns the count without disturbing it.
// - Writing 0..59 loads seconds; other values ignored.
// - Seconds wrap to 0 after 59.
// - Seconds writes blocked while write protection is on.
// - Two %10 key writes lock; %00,%01,%11,%10 unlock; key reads zero.
// - Enable bits 5,4,3,2,0 gate their matching flags.
// - Q at or above cycle length uses modulo+1 for every match.
//
// Our own choices: the register addresses and register access over Avalon-MM.
`timescale 1ns/1ns
`default_nettype none
module rtcs_top
  import rtcs_pkg::*;
#(
  // Clocks the load bit stays set while buffers are copied
  parameter int LOAD_LEN = LOAD_CYCLES
)
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Counter clock enable (prescaled time base)
  input wire logic cnt_en,
  // Avalon-MM slave
  input wire logic [ADDR_W+1:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  // Interrupt request
  output logic irq
);
  // ==========================================
  // Bus handshake: one wait cycle, then answer
  logic ack_ff;
  logic wait_ff;
  logic nxt_ack;
  logic [31:0] rdata_ff;
  logic irq_ff;
  logic [ADDR_W-1:0] widx;
  logic wr_go;
  logic [7:0] wd8;

  assign widx = avs_address[ADDR_W+1:2];
  assign wr_go = avs_write && ack_ff;
  assign wd8 = avs_writedata[7:0];
  assign nxt_ack = (avs_read || avs_write) && !ack_ff;
  assign avs_waitrequest = wait_ff;
  assign avs_readdata = rdata_ff;
  assign irq = irq_ff;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ack_ff <= 1'b0;
      wait_ff <= 1'b1;
    end else begin
      ack_ff <= nxt_ack;
      // Own flop so the bus never sees a glitch on waitrequest
      wait_ff <= !nxt_ack;
    end
  end

  function automatic logic hit(input logic [ADDR_W-1:0] idx);
    return wr_go && widx == idx;
  endfunction

  // ==========================================
  // Registers
  logic [7:0] flags_ff;
  logic [7:0] irq_en_ff;
  logic [7:0] comp_cfg_ff;
  logic [15:0] modulo_ff;
  logic [15:0] cnt_ff;
  logic [5:0] sec_ff;
  logic [5:0] min_ff;
  logic [4:0] hour_ff;
  logic run_en_ff;
  logic load_ff;
  logic [1:0] load_cnt_ff;
  logic [1:0] ccs_buf_ff;
  logic [5:0] q_buf_ff;
  logic [15:0] mod_buf_ff;
  logic [6:0] cyc_sec_ff;
  logic [15:0] tick_cnt_ff;
  logic [1:0] qtr_ff;
  logic locked;

  // ==========================================
  // Parameter checks
  // Load counter is two bits wide, longer copies cannot be counted
  if (LOAD_LEN < 1 || LOAD_LEN > 4) begin : g_bad_load
    $error("load length out of range");
  end
  // A status write must never clear the load bit
  if (EVENT_MASK[BIT_LOAD] != 1'b0) begin : g_bad_mask
    $error("load bit inside event mask");
  end

  // ==========================================
  // Write protection
  rtcs_prot u_prot (
    .clk(clk),
    .rst(rst),
    .key_wr(hit(ADDR_PROTECT)),
    .key_val(wd8[PKEY_HI:PKEY_LO]),
    .locked_ff(locked)
  );

  // ==========================================
  // Control registers
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      irq_en_ff <= 8'h00;
      run_en_ff <= 1'b0;
    end else begin
      if (hit(ADDR_IRQ_EN)) begin
        irq_en_ff <= wd8 & EVENT_MASK;
      end
      // Starting the counter also reloads the buffers
      if (hit(ADDR_CTRL)) begin
        run_en_ff <= wd8[CTRL_EN];
      end
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      comp_cfg_ff <= 8'h00;
      modulo_ff <= MOD_RST;
    end else if (!load_ff) begin
      if (hit(ADDR_COMP_CFG)) begin
        comp_cfg_ff <= wd8;
      end
      if (hit(ADDR_MODULO)) begin
        modulo_ff <= avs_writedata[15:0];
      end
    end
  end

  // ==========================================
  // Compensation engine
  logic [6:0] cyc_len;
  logic [15:0] match_val;
  logic cnt_wrap;
  logic sec_inc;
  logic cyc_last;
  logic use_plus;

  always_comb begin
    case (ccs_buf_ff)
      2'h0: cyc_len = CYC_5;
      2'h1: cyc_len = CYC_15;
      2'h2: cyc_len = CYC_30;
      default: cyc_len = CYC_60;
    endcase
  end

  // Q of zero never selects plus one; Q past the cycle selects it always
  assign use_plus = {1'b0, q_buf_ff} > cyc_sec_ff;
  assign match_val = use_plus ? mod_buf_ff + 16'h0001 : mod_buf_ff;
  // Wrap on at-or-above so a lowered match value cannot run away
  assign cnt_wrap = run_en_ff && cnt_en && cnt_ff >= match_val;
  assign sec_inc = cnt_wrap;
  assign cyc_last = sec_inc && cyc_sec_ff == cyc_len - 7'h01;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cnt_ff <= CNT_RST;
    end else if (cnt_wrap) begin
      cnt_ff <= CNT_RST;
    end else if (run_en_ff && cnt_en) begin
      cnt_ff <= cnt_ff + 16'h0001;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cyc_sec_ff <= 7'h00;
    end else if (sec_inc) begin
      cyc_sec_ff <= cyc_last ? 7'h00 : cyc_sec_ff + 7'h01;
    end
  end

  // Config copied into buffers at cycle end; copy spans a few clocks
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      load_ff <= 1'b0;
      load_cnt_ff <= 2'h0;
      ccs_buf_ff <= 2'h0;
      q_buf_ff <= 6'h00;
      mod_buf_ff <= MOD_RST;
    end else if (load_ff) begin
      if (load_cnt_ff == 2'(LOAD_LEN - 1)) begin
        load_ff <= 1'b0;
        ccs_buf_ff <= comp_cfg_ff[CCS_HI:CCS_LO];
        q_buf_ff <= comp_cfg_ff[Q_HI:0];
        mod_buf_ff <= modulo_ff;
      end
      load_cnt_ff <= load_cnt_ff + 2'h1;
    end else if (cyc_last || (!run_en_ff && hit(ADDR_CTRL) && wd8[CTRL_EN])) begin
      load_ff <= 1'b1;
      load_cnt_ff <= 2'h0;
    end
  end

  // ==========================================
  // 4 Hz tick from counter position
  logic tick;
  logic [15:0] quarter;
  assign quarter = {2'h0, match_val[15:2]};
  assign tick = run_en_ff && cnt_en &&
                (cnt_wrap || (cnt_ff == tick_cnt_ff && qtr_ff != 2'h0));

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      tick_cnt_ff <= 16'h0000;
      qtr_ff <= 2'h0;
    end else if (!run_en_ff) begin
      // Preset so the first second after start has quarter ticks too
      tick_cnt_ff <= quarter;
      qtr_ff <= TICKS_PER_SEC;
    end else if (cnt_wrap) begin
      tick_cnt_ff <= quarter;
      qtr_ff <= TICKS_PER_SEC;
    end else if (tick) begin
      tick_cnt_ff <= tick_cnt_ff + quarter;
      qtr_ff <= qtr_ff - 2'h1;
    end
  end

  // ==========================================
  // Calendar counters
  logic sec_ok;
  logic min_inc;
  logic hour_inc;
  assign sec_ok = wd8 <= {2'h0, SEC_MAX};
  assign min_inc = sec_inc && sec_ff == SEC_MAX;
  assign hour_inc = min_inc && min_ff == MIN_MAX;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      sec_ff <= 6'h00;
    end else if (hit(ADDR_SECONDS) && sec_ok && !locked) begin
      // A write in the same clock as an increment wins
      sec_ff <= wd8[5:0];
    end else if (sec_inc) begin
      sec_ff <= (sec_ff == SEC_MAX) ? 6'h00 : sec_ff + 6'h01;
    end
  end

  // Minute and hour only feed their flags here
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      min_ff <= 6'h00;
      hour_ff <= 5'h00;
    end else begin
      if (min_inc) begin
        min_ff <= (min_ff == MIN_MAX) ? 6'h00 : min_ff + 6'h01;
      end
      if (hour_inc) begin
        hour_ff <= (hour_ff == HOUR_MAX) ? 5'h00 : hour_ff + 5'h01;
      end
    end
  end

  // ==========================================
  // Event flags: set wins over clear
  logic [7:0] ev_set;
  logic [7:0] ev_clr;
  always_comb begin
    ev_set = 8'h00;
    ev_set[BIT_HOUR] = hour_inc;
    ev_set[BIT_MIN] = min_inc;
    ev_set[BIT_SEC] = sec_inc;
    ev_set[BIT_COMP] = cyc_last;
    ev_set[BIT_TICK] = tick;
    ev_clr = hit(ADDR_STATUS) ? (wd8 & EVENT_MASK) : 8'h00;
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      flags_ff <= 8'h00;
    end else begin
      flags_ff <= ((flags_ff & ~ev_clr) | ev_set) & EVENT_MASK;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      irq_ff <= 1'b0;
    end else begin
      // Registered so the request line cannot glitch
      irq_ff <= |(flags_ff & irq_en_ff);
    end
  end

  // ==========================================
  // Read mux; count is a live snapshot, software reads twice
  logic [31:0] rd_mux;
  always_comb begin
    rd_mux = 32'h0000_0000;
    case (widx)
      ADDR_STATUS: rd_mux[7:0] = flags_ff | {load_ff, 7'h00};
      ADDR_IRQ_EN: rd_mux[7:0] = irq_en_ff;
      ADDR_PROTECT: rd_mux[7:0] = {7'h00, locked};
      ADDR_COMP_CFG: rd_mux[7:0] = comp_cfg_ff;
      ADDR_FREE_CNT: rd_mux[15:0] = cnt_ff;
      ADDR_MODULO: rd_mux[15:0] = modulo_ff;
      ADDR_SECONDS: rd_mux[5:0] = sec_ff;
      ADDR_CTRL: rd_mux[0] = run_en_ff;
      default: rd_mux = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rdata_ff <= 32'h0000_0000;
    end else if (avs_read && !ack_ff) begin
      // Taken when the request is first seen, stable by the answer
      rdata_ff <= rd_mux;
    end
  end
endmodule
`default_nettype wire

// ### verif/rtc_status_compensation_seconds_tb_top.sv
`timescale 1ns/1ns
`default_nettype none
`define CHK(nm, e, s) begin \
  n_checks++; \
  if ((s) !== (e)) begin \
    miscompares++; \
    $display("mismatch %s exp %h seen %h", nm, e, s); \
  end \
end
module rtc_status_compensation_seconds_tb_top
  import rtcs_pkg::*;
;
  // ========
  // Signals
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic cnt_en = 1'b0;
  logic [5:0] avs_address = 6'h00;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  logic [31:0] avs_readdata;
  logic avs_waitrequest;
  logic irq;
  logic wait_s;
  logic irq_s;
  logic [31:0] rd_s;
  logic [31:0] rdv;
  logic [1:0] keys [4] = '{2'h0, 2'h1, 2'h3, 2'h2};
  int miscompares = 0;
  int n_checks = 0;
  localparam logic [5:0] A_ST = {ADDR_STATUS, 2'h0};
  localparam logic [5:0] A_IEN = {ADDR_IRQ_EN, 2'h0};
  localparam logic [5:0] A_KEY = {ADDR_PROTECT, 2'h0};
  localparam logic [5:0] A_CFG = {ADDR_COMP_CFG, 2'h0};
  localparam logic [5:0] A_CNT = {ADDR_FREE_CNT, 2'h0};
  localparam logic [5:0] A_MOD = {ADDR_MODULO, 2'h0};
  localparam logic [5:0] A_SEC = {ADDR_SECONDS, 2'h0};
  localparam logic [5:0] A_CTL = {ADDR_CTRL, 2'h0};
  rtcs_top uut (.clk(clk), .rst(rst), .cnt_en(cnt_en),
    .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .irq(irq));
  initial begin
    forever #10 clk = ~clk;
  end
  // Sampled mid-cycle so edge checks never race the design
  always @(negedge clk) begin
    wait_s <= avs_waitrequest;
    irq_s <= irq;
    rd_s <= avs_readdata;
  end
  // ========
  // Tasks
  task automatic close_out();
    $display("checks %0d mismatches %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  task automatic bus_wait();
    int i;
    i = 0;
    do begin
      @(posedge clk);
      i++;
    end while (wait_s !== 1'b0 && i < 64);
    if (wait_s !== 1'b0) begin
      miscompares++;
      close_out();
    end
  endtask
  task automatic wr(input logic [5:0] a, input logic [31:0] d);
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= 1'b1;
    bus_wait();
    avs_write <= 1'b0;
    @(posedge clk);
  endtask
  task automatic rd(input logic [5:0] a, output logic [31:0] d);
    avs_address <= a;
    avs_read <= 1'b1;
    bus_wait();
    d = rd_s;
    avs_read <= 1'b0;
    @(posedge clk);
  endtask
  task automatic rc(input logic [5:0] a, input logic [31:0] e, string nm);
    rd(a, rdv);
    `CHK(nm, e, rdv)
  endtask
  task automatic pulse(input int n);
    repeat (n) begin
      cnt_en <= 1'b1;
      @(posedge clk);
      cnt_en <= 1'b0;
      @(posedge clk);
    end
    repeat (4) @(posedge clk);
  endtask
  // ========
  // Sequence
  initial begin
    repeat (20000) @(posedge clk);
    miscompares++;
    close_out();
  end
  initial begin
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    rc(A_CNT, 32'h0, "count");
    rc(A_MOD, 32'h0, "modulo");
    rc(A_ST, 32'h0, "status");
    rc(6'h24, 32'h0, "unmapped");
    wr(A_CNT, 32'h1234);
    rc(A_CNT, 32'h0, "count");
    wr(A_MOD, 32'h3);
    rc(A_MOD, 32'h3, "modulo");
    wr(A_CFG, 32'hc5);
    rc(A_CFG, 32'hc5, "cfg");
    wr(A_CFG, 32'h01); // 5 s cycle, one long second
    wr(A_SEC, 32'h2d);
    wr(A_SEC, 32'h3c);
    rc(A_SEC, 32'h2d, "seconds");
    wr(A_ST, 32'h80);
    rc(A_ST, 32'h0, "load bit");
    wr(A_KEY, 32'h80);
    wr(A_KEY, 32'h80);
    rc(A_KEY, 32'h1, "locked");
    wr(A_SEC, 32'h3a);
    rc(A_SEC, 32'h2d, "seconds");
    foreach (keys[k]) wr(A_KEY, {24'h0, keys[k], 6'h0});
    rc(A_KEY, 32'h0, "locked");
    wr(A_SEC, 32'h3a);
    rc(A_SEC, 32'h3a, "seconds");
    wr(A_IEN, 32'h08);
    wr(A_CTL, 32'h1);
    rc(A_ST, 32'h80, "load bit");
    repeat (8) @(posedge clk);
    pulse(4);
    rc(A_SEC, 32'h3a, "seconds");
    rc(A_CNT, 32'h4, "count");
    rc(A_CNT, 32'h4, "count");
    pulse(1);
    rc(A_SEC, 32'h3b, "seconds");
    rd(A_ST, rdv);
    `CHK("sec flag", 1'b1, rdv[BIT_SEC])
    `CHK("tick flag", 1'b1, rdv[BIT_TICK])
    `CHK("irq", 1'b1, irq_s)
    wr(A_IEN, 32'h0);
    repeat (3) @(posedge clk);
    `CHK("irq", 1'b0, irq_s)
    wr(A_IEN, 32'h08);
    wr(A_ST, 32'h3d);
    repeat (3) @(posedge clk);
    `CHK("irq", 1'b0, irq_s)
    rc(A_ST, 32'h0, "status");
    pulse(4);
    rc(A_SEC, 32'h0, "seconds");
    rd(A_ST, rdv);
    `CHK("min flag", 1'b1, rdv[BIT_MIN])
    pulse(12);
    rd(A_ST, rdv);
    `CHK("comp flag", 1'b1, rdv[BIT_COMP])
    // Q equal to the cycle length: every second counts modulo plus one
    wr(A_CTL, 32'h0);
    wr(A_CFG, 32'h05);
    wr(A_CTL, 32'h1);
    wr(A_SEC, 32'h0);
    pulse(24);
    rc(A_SEC, 32'h4, "seconds");
    rc(A_CNT, 32'h4, "count");
    wr(A_ST, 32'h3d);
    // Modulo write lands while the cycle-end load is running
    fork
      pulse(1);
      wr(A_MOD, 32'h7);
    join
    rc(A_MOD, 32'h3, "modulo");
    rc(A_ST, 32'h0d, "status");
    // Q zero on a 60 s cycle: one plain match per second
    wr(A_CTL, 32'h0);
    wr(A_MOD, 32'h0);
    rc(A_MOD, 32'h0, "modulo");
    wr(A_CFG, 32'hc0);
    wr(A_CTL, 32'h1);
    wr(A_ST, 32'h3d);
    pulse(59);
    rc(A_SEC, 32'h4, "seconds");
    rd(A_ST, rdv);
    `CHK("comp flag", 1'b0, rdv[BIT_COMP])
    pulse(1);
    rd(A_ST, rdv);
    `CHK("comp flag", 1'b1, rdv[BIT_COMP])
    // Run the minutes up to the hour rollover
    wr(A_SEC, 32'h0);
    wr(A_ST, 32'h3d);
    pulse(3479);
    rd(A_ST, rdv);
    `CHK("hour flag", 1'b0, rdv[BIT_HOUR])
    rc(A_SEC, 32'h3b, "seconds");
    pulse(1);
    rd(A_ST, rdv);
    `CHK("hour flag", 1'b1, rdv[BIT_HOUR])
    rc(A_SEC, 32'h0, "seconds");
    close_out();
  end
endmodule
`default_nettype wire

// ### verif/rtcs_chk_sva.sv
`timescale 1ns/1ns
`default_nettype none
module rtcs_chk
  import rtcs_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  input wire logic cnt_en,
  // Bus
  input wire logic [ADDR_W+1:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [31:0] avs_readdata,
  input wire logic avs_waitrequest,
  // Interrupt
  input wire logic irq
);
  // ========
  // Sequences
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  sequence s_taken;
    (avs_read || avs_write) && avs_waitrequest;
  endsequence
  sequence s_rd(logic [3:0] ix);
    avs_read && avs_waitrequest && avs_address[5:2] == ix;
  endsequence
  // ========
  // Bus answer
  chk_wait_answer:
    assert property (s_taken |=> !avs_waitrequest)
    else $error("request not answered");
  chk_wait_pulse:
    assert property ($fell(avs_waitrequest) |=> avs_waitrequest)
    else $error("waitrequest low too long");
  // Read data moves only when a read is taken
  chk_rdata_hold:
    assert property ($changed(avs_readdata) |-> $past(avs_read && avs_waitrequest))
    else $error("read data changed without read");
  chk_unmapped_zero:
    assert property (avs_read && avs_waitrequest && avs_address[5]
      |=> avs_readdata == 32'h0)
    else $error("unmapped read not zero");
  // ========
  // Register contents
  chk_count_width:
    assert property (s_rd(ADDR_FREE_CNT) |=> avs_readdata[31:16] == 16'h0)
    else $error("free count wider than 16 bits");
  chk_sec_range:
    assert property (s_rd(ADDR_SECONDS) |=> avs_readdata <= 32'h3b)
    else $error("seconds above 59");
  chk_status_bits:
    assert property (s_rd(ADDR_STATUS) |=> (avs_readdata & 32'hffffff42) == 0)
    else $error("status reserved bit set");
  chk_key_zero:
    assert property (s_rd(ADDR_PROTECT) |=> avs_readdata[7:6] == 2'h0)
    else $error("key field not zero");
endmodule
bind rtcs_top rtcs_chk u_chk (.clk(clk), .rst(rst), .cnt_en(cnt_en),
  .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
  .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
  .avs_waitrequest(avs_waitrequest), .irq(irq));
`default_nettype wire
